// ==== rtl/dci_device.sv ====
// device end: command channel interpreter, setting store and plate control decode
//
// The register offsets and the plain strobed port were chosen for this implementation.
module dci_device (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    dci_image_if.device img,
    input wire logic [dci_pkg::STYLES_W-1:0] style_count_i,
    output logic cmd_busy_o,
    output logic style_strobe_o,
    output logic dispense_done_o,
    output logic [dci_pkg::VALVE_N-1:0] valve_on_o,
    output logic error_reset_o,
    output logic remote_start_o,
    output logic [dci_pkg::STYLE_W-1:0] style_num_o,
    output logic [dci_pkg::VALVE_N-1:0] precharge_on_o
);

    // =========================================================
    // state record
    typedef struct packed {
        dci_pkg::dci_dev_state_type st;
        logic armed;
        logic [dci_pkg::CNT_W-1:0] cnt;
        logic is_write;
        logic fail_pend;
        logic [dci_pkg::TIDX_W-1:0] tidx;
        logic [dci_pkg::SLOT_W-1:0] slot;
        logic [dci_pkg::VAL_W-1:0] wval;
        logic [dci_pkg::VAL_W-1:0] ret;
        logic active;
        logic success;
        logic failure;
        logic coerced;
        logic [dci_pkg::WORD_W-1:0] ctl;
        logic [dci_pkg::WORD_W-1:0] style;
        logic [dci_pkg::WORD_W-1:0] pre;
    } dci_dev_regs_type;

    dci_dev_regs_type regs_r;
    dci_dev_regs_type regs_nxt;

    // setting store, one page of slots per target
    logic [dci_pkg::VAL_W-1:0] store_r [dci_pkg::N_SLOTS];
    logic store_we;
    logic [dci_pkg::TIDX_W+dci_pkg::SLOT_W-1:0] store_addr;
    logic [dci_pkg::VAL_W-1:0] store_wdata;

    // image fields
    logic req_rd;
    logic req_wr;
    logic req_any;
    logic serviced;
    logic [dci_pkg::CODE_W-1:0] code_in;
    logic [dci_pkg::TGT_W-1:0] tgt_in;
    logic [dci_pkg::VAL_W-1:0] val_in;
    logic tgt_ok;
    logic [dci_pkg::TIDX_W-1:0] tidx_in;
    logic code_ok;
    logic [dci_pkg::VAL_W-1:0] clamped;

    // =========================================================
    // decode helpers

    // map a selector onto a store page; plates first, then orbital units
    function automatic logic [dci_pkg::TIDX_W:0] decode_target(input logic [dci_pkg::TGT_W-1:0] sel);
        logic [dci_pkg::TGT_W-1:0] off;
        off = '0;
        if (sel >= dci_pkg::TGT_PLATE_FIRST && sel <= dci_pkg::TGT_PLATE_LAST) begin
            off = sel - dci_pkg::TGT_PLATE_FIRST;
            return {1'b1, off[dci_pkg::TIDX_W-1:0]};
        end
        if (sel >= dci_pkg::TGT_ORBIT_FIRST && sel <= dci_pkg::TGT_ORBIT_LAST) begin
            off = sel - dci_pkg::TGT_ORBIT_FIRST;
            return {1'b1, dci_pkg::TIDX_ORBIT_BASE | off[dci_pkg::TIDX_W-1:0]};
        end
        return '0;
    endfunction

    // field extraction from the output image, positions relative to its base
    assign req_rd = img.out_img[dci_pkg::BIT_READ-dci_pkg::OUT_BASE];
    assign req_wr = img.out_img[dci_pkg::BIT_WRITE-dci_pkg::OUT_BASE];
    assign req_any = req_rd | req_wr;
    assign code_in = img.out_img[dci_pkg::BIT_CODE_LSB-dci_pkg::OUT_BASE +: dci_pkg::CODE_W];
    assign tgt_in = img.out_img[dci_pkg::BIT_TGT_LSB-dci_pkg::OUT_BASE +: dci_pkg::TGT_W];
    assign val_in = img.out_img[dci_pkg::BIT_VAL_LSB-dci_pkg::OUT_BASE +: dci_pkg::VAL_W];
    assign {tgt_ok, tidx_in} = decode_target(tgt_in);

    // only the settings page holds storage; any other code fails
    assign code_ok = code_in[dci_pkg::CODE_W-1:dci_pkg::SLOT_W] == dci_pkg::SET_PAGE;

    // plates without a 16 or 256 style table get no channel at all
    assign serviced = style_count_i == dci_pkg::STYLES_SMALL || style_count_i == dci_pkg::STYLES_LARGE;

    // values above the limit are clipped before they are stored
    assign clamped = (regs_r.wval > dci_pkg::SET_LIMIT) ? dci_pkg::SET_LIMIT : regs_r.wval;

    // =========================================================
    // next state
    always_comb begin
        regs_nxt = regs_r;
        store_we = 1'b0;
        store_addr = {regs_r.tidx, regs_r.slot};
        store_wdata = clamped;
        // plate words pass through one register stage
        regs_nxt.ctl = img.ctl2_word;
        regs_nxt.style = img.style2_word;
        regs_nxt.pre = img.pre1_word;
        case (regs_r.st)
            dci_pkg::DEV_IDLE: begin
                // a bit left high across reset must drop once before it counts
                if (!req_any) begin
                    regs_nxt.armed = 1'b1;
                end
                if (regs_r.armed && req_any && serviced) begin
                    regs_nxt.st = dci_pkg::DEV_BUSY;
                    regs_nxt.active = 1'b1;
                    regs_nxt.cnt = dci_pkg::PROC_CYCLES - 3'h1;
                    regs_nxt.is_write = req_wr;
                    regs_nxt.fail_pend = (req_rd & req_wr) | !tgt_ok | !code_ok;
                    regs_nxt.tidx = tidx_in;
                    regs_nxt.slot = code_in[dci_pkg::SLOT_W-1:0];
                    regs_nxt.wval = val_in;
                end
            end
            dci_pkg::DEV_BUSY: begin
                if (req_rd && req_wr) begin
                    regs_nxt.fail_pend = 1'b1;
                end
                if (!req_any) begin
                    // controller gave up: abandon without touching the store
                    regs_nxt.st = dci_pkg::DEV_IDLE;
                    regs_nxt.active = 1'b0;
                end else if (regs_r.cnt != dci_pkg::CNT_RESET) begin
                    regs_nxt.cnt = regs_r.cnt - 3'h1;
                end else begin
                    regs_nxt.st = dci_pkg::DEV_DONE;
                    regs_nxt.active = 1'b0;
                    if (regs_r.fail_pend || (req_rd && req_wr)) begin
                        regs_nxt.failure = 1'b1;
                    end else if (regs_r.is_write) begin
                        store_we = 1'b1;
                        regs_nxt.ret = clamped;
                        if (clamped != regs_r.wval) begin
                            regs_nxt.coerced = 1'b1;
                        end else begin
                            regs_nxt.success = 1'b1;
                        end
                    end else begin
                        regs_nxt.ret = store_r[store_addr];
                        regs_nxt.success = 1'b1;
                    end
                end
            end
            dci_pkg::DEV_DONE: begin
                // result flags stand until the controller drops its bit
                if (!req_any) begin
                    regs_nxt.st = dci_pkg::DEV_IDLE;
                    regs_nxt.success = 1'b0;
                    regs_nxt.failure = 1'b0;
                    regs_nxt.coerced = 1'b0;
                end
            end
            default: begin
                regs_nxt.st = dci_pkg::DEV_IDLE;
            end
        endcase
    end

    // =========================================================
    // state register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            regs_r <= '{st: dci_pkg::DEV_IDLE, armed: 1'b0, cnt: dci_pkg::CNT_RESET, is_write: 1'b0,
                        fail_pend: 1'b0, tidx: '0, slot: '0, wval: dci_pkg::VAL_RESET,
                        ret: dci_pkg::VAL_RESET, active: 1'b0, success: 1'b0, failure: 1'b0,
                        coerced: 1'b0, ctl: dci_pkg::WORD_RESET, style: dci_pkg::WORD_RESET,
                        pre: dci_pkg::WORD_RESET};
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // store kept apart from the record so it can map onto a memory
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < dci_pkg::N_SLOTS; i++) begin
                store_r[i] <= dci_pkg::SET_RESET_VALUE;
            end
        end else if (store_we) begin
            store_r[store_addr] <= store_wdata;
        end
    end

    // =========================================================
    // outputs
    // input image, bit 163 down to bit 128
    assign img.in_img = {regs_r.coerced, regs_r.failure, regs_r.success, regs_r.active, regs_r.ret};
    assign cmd_busy_o = regs_r.active;

    // plate control fields
    assign style_strobe_o = regs_r.ctl[dci_pkg::CTL_STROBE];
    assign dispense_done_o = regs_r.ctl[dci_pkg::CTL_DONE];
    assign valve_on_o = regs_r.ctl[dci_pkg::CTL_VALVE_LSB +: dci_pkg::VALVE_N];
    assign error_reset_o = regs_r.ctl[dci_pkg::CTL_ERR_RST];
    assign remote_start_o = regs_r.ctl[dci_pkg::CTL_START];
    assign style_num_o = regs_r.style[dci_pkg::STYLE_LSB +: dci_pkg::STYLE_W];
    // spare precharge bits 4..7 are ignored
    assign precharge_on_o = regs_r.pre[dci_pkg::PRE_LSB +: dci_pkg::VALVE_N];

endmodule

// ==== rtl/dci_pkg.sv ====
// shared constants and types of the dispense command interface
package dci_pkg;

    // =========================================================
    // automation output image (controller drives, device reads)
    localparam int OUT_BASE = 256;
    localparam int OUT_TOP = 327;
    localparam int OUT_W = OUT_TOP - OUT_BASE + 1;
    localparam int BIT_CODE_LSB = 256;
    localparam int CODE_W = 12;
    localparam int BIT_TGT_LSB = 268;
    localparam int TGT_W = 8;
    localparam int BIT_VAL_LSB = 288;
    localparam int VAL_W = 32;
    localparam int BIT_READ = 320;
    localparam int BIT_WRITE = 321;
    localparam int SPARE_MID_W = BIT_VAL_LSB - (BIT_TGT_LSB + TGT_W);
    localparam int SPARE_HI_W = OUT_TOP - BIT_WRITE;

    // =========================================================
    // automation input image (device drives, controller reads)
    localparam int IN_BASE = 128;
    localparam int IN_TOP = 163;
    localparam int IN_W = IN_TOP - IN_BASE + 1;
    localparam int BIT_RET_LSB = 128;
    localparam int BIT_ACTIVE = 160;
    localparam int BIT_SUCCESS = 161;
    localparam int BIT_FAILURE = 162;
    localparam int BIT_COERCED = 163;

    // =========================================================
    // per-plate control words
    localparam int WORD_W = 16;
    localparam int CTL_STROBE = 0;
    localparam int CTL_DONE = 1;
    localparam int CTL_VALVE_LSB = 2;
    localparam int VALVE_N = 4;
    localparam int CTL_ERR_RST = 6;
    localparam int CTL_START = 7;
    localparam int STYLE_LSB = 0;
    localparam int STYLE_W = 8;
    localparam int PRE_LSB = 0;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    // =========================================================
    // target selector codes
    localparam logic [TGT_W-1:0] TGT_PLATE_FIRST = 8'hB0;
    localparam logic [TGT_W-1:0] TGT_PLATE_LAST = 8'hB3;
    localparam logic [TGT_W-1:0] TGT_ORBIT_FIRST = 8'hE1;
    localparam logic [TGT_W-1:0] TGT_ORBIT_LAST = 8'hE4;
    localparam int TIDX_W = 3;
    localparam logic [TIDX_W-1:0] TIDX_ORBIT_BASE = 3'h4;

    // =========================================================
    // style configurations that own a command channel
    localparam int STYLES_W = 9;
    localparam logic [STYLES_W-1:0] STYLES_SMALL = 9'h010;
    localparam logic [STYLES_W-1:0] STYLES_LARGE = 9'h100;

    // =========================================================
    // setting store: page of codes, slots per target, limits
    localparam logic [CODE_W-5:0] SET_PAGE = 8'h20;
    localparam int SLOT_W = 4;
    localparam int N_SLOTS = 128;
    localparam logic [VAL_W-1:0] SET_RESET_VALUE = 32'h0000_0000;
    localparam logic [VAL_W-1:0] SET_LIMIT = 32'h0000_FFFF;
    localparam logic [VAL_W-1:0] VAL_RESET = 32'h0000_0000;

    // =========================================================
    // processing latency of one command
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] PROC_CYCLES = 3'h4;
    localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;

    typedef enum logic [1:0] {DEV_IDLE, DEV_BUSY, DEV_DONE} dci_dev_state_type;
    typedef enum logic [2:0] {HST_IDLE, HST_SETUP, HST_ACT, HST_RES, HST_CLR} dci_hst_state_type;

endpackage

// ==== rtl/dci_image_if.sv ====
// bit-mapped fieldbus image shared by controller and device
interface dci_image_if;
    // output image bits 256..327, bit 0 of the vector is bit 256
    logic [dci_pkg::OUT_W-1:0] out_img;
    // input image bits 128..163, bit 0 of the vector is bit 128
    logic [dci_pkg::IN_W-1:0] in_img;
    // second plate control word, its style word, first plate precharge word
    logic [dci_pkg::WORD_W-1:0] ctl2_word;
    logic [dci_pkg::WORD_W-1:0] style2_word;
    logic [dci_pkg::WORD_W-1:0] pre1_word;

    modport device (
        input out_img,
        input ctl2_word,
        input style2_word,
        input pre1_word,
        output in_img
    );

    modport host (
        output out_img,
        output ctl2_word,
        output style2_word,
        output pre1_word,
        input in_img
    );
endinterface

// ==== rtl/dci_host.sv ====
// controller end: drives the command channel handshake and the plate control words
module dci_host (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    dci_image_if.host img,
    input wire logic cmd_start_i,
    input wire logic cmd_write_i,
    input wire logic [dci_pkg::CODE_W-1:0] cmd_code_i,
    input wire logic [dci_pkg::TGT_W-1:0] cmd_target_i,
    input wire logic [dci_pkg::VAL_W-1:0] cmd_value_i,
    input wire logic [dci_pkg::WORD_W-1:0] ctl2_word_i,
    input wire logic [dci_pkg::WORD_W-1:0] style2_word_i,
    input wire logic [dci_pkg::WORD_W-1:0] pre1_word_i,
    output logic cmd_busy_o,
    output logic cmd_done_o,
    output logic cmd_ok_o,
    output logic cmd_fail_o,
    output logic cmd_coerced_o,
    output logic [dci_pkg::VAL_W-1:0] cmd_value_o
);

    // =========================================================
    // state record
    typedef struct packed {
        dci_pkg::dci_hst_state_type st;
        logic [dci_pkg::CODE_W-1:0] code;
        logic [dci_pkg::TGT_W-1:0] tgt;
        logic [dci_pkg::VAL_W-1:0] val;
        logic is_write;
        logic rd;
        logic wr;
        logic done;
        logic ok;
        logic fail;
        logic coer;
        logic [dci_pkg::VAL_W-1:0] rdval;
        logic [dci_pkg::WORD_W-1:0] ctl;
        logic [dci_pkg::WORD_W-1:0] style;
        logic [dci_pkg::WORD_W-1:0] pre;
    } dci_hst_regs_type;

    dci_hst_regs_type regs_r;
    dci_hst_regs_type regs_nxt;

    logic act_in;
    logic res_any;

    assign act_in = img.in_img[dci_pkg::BIT_ACTIVE-dci_pkg::IN_BASE];
    assign res_any = |img.in_img[dci_pkg::BIT_SUCCESS-dci_pkg::IN_BASE +: 3];

    // =========================================================
    // next state: fields first, then request bit, then wait three times
    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.done = 1'b0;
        regs_nxt.ctl = ctl2_word_i;
        regs_nxt.style = style2_word_i;
        regs_nxt.pre = pre1_word_i;
        case (regs_r.st)
            dci_pkg::HST_IDLE: begin
                if (cmd_start_i) begin
                    regs_nxt.st = dci_pkg::HST_SETUP;
                    regs_nxt.code = cmd_code_i;
                    regs_nxt.tgt = cmd_target_i;
                    regs_nxt.val = cmd_write_i ? cmd_value_i : dci_pkg::VAL_RESET;
                    regs_nxt.is_write = cmd_write_i;
                end
            end
            dci_pkg::HST_SETUP: begin
                // fields stood one cycle before the request bit rises
                regs_nxt.wr = regs_r.is_write;
                regs_nxt.rd = !regs_r.is_write;
                regs_nxt.st = dci_pkg::HST_ACT;
            end
            dci_pkg::HST_ACT: begin
                if (act_in) begin
                    regs_nxt.st = dci_pkg::HST_RES;
                end
            end
            dci_pkg::HST_RES: begin
                if (res_any) begin
                    regs_nxt.ok = img.in_img[dci_pkg::BIT_SUCCESS-dci_pkg::IN_BASE];
                    regs_nxt.fail = img.in_img[dci_pkg::BIT_FAILURE-dci_pkg::IN_BASE];
                    regs_nxt.coer = img.in_img[dci_pkg::BIT_COERCED-dci_pkg::IN_BASE];
                    regs_nxt.rdval = img.in_img[dci_pkg::BIT_RET_LSB-dci_pkg::IN_BASE +: dci_pkg::VAL_W];
                    regs_nxt.rd = 1'b0;
                    regs_nxt.wr = 1'b0;
                    regs_nxt.st = dci_pkg::HST_CLR;
                end
            end
            dci_pkg::HST_CLR: begin
                // next command only after the device has cleared its flags
                if (!res_any && !act_in) begin
                    regs_nxt.done = 1'b1;
                    regs_nxt.st = dci_pkg::HST_IDLE;
                end
            end
            default: begin
                regs_nxt.st = dci_pkg::HST_IDLE;
            end
        endcase
    end

    // =========================================================
    // state register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            regs_r <= '{st: dci_pkg::HST_IDLE, code: '0, tgt: '0, val: dci_pkg::VAL_RESET, is_write: 1'b0,
                        rd: 1'b0, wr: 1'b0, done: 1'b0, ok: 1'b0, fail: 1'b0, coer: 1'b0,
                        rdval: dci_pkg::VAL_RESET, ctl: dci_pkg::WORD_RESET,
                        style: dci_pkg::WORD_RESET, pre: dci_pkg::WORD_RESET};
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // =========================================================
    // outputs: image bit 327 down to bit 256
    assign img.out_img = {{dci_pkg::SPARE_HI_W{1'b0}}, regs_r.wr, regs_r.rd, regs_r.val,
                          {dci_pkg::SPARE_MID_W{1'b0}}, regs_r.tgt, regs_r.code};
    assign img.ctl2_word = regs_r.ctl;
    assign img.style2_word = regs_r.style;
    assign img.pre1_word = regs_r.pre;
    assign cmd_busy_o = regs_r.st != dci_pkg::HST_IDLE;
    assign cmd_done_o = regs_r.done;
    assign cmd_ok_o = regs_r.ok;
    assign cmd_fail_o = regs_r.fail;
    assign cmd_coerced_o = regs_r.coer;
    assign cmd_value_o = regs_r.rdval;

endmodule

// ==== sim/dci_checker.sv ====
// concurrent checks on the image that joins the controller end to the device end
module dci_checker (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [dci_pkg::OUT_W-1:0] out_img,
    input wire logic [dci_pkg::IN_W-1:0] in_img,
    input wire logic [dci_pkg::WORD_W-1:0] ctl2_word,
    input wire logic [dci_pkg::WORD_W-1:0] style2_word,
    input wire logic [dci_pkg::WORD_W-1:0] pre1_word
);
    // =========================================================
    // request and result views of the image
    wire logic req = out_img[64] | out_img[65];
    wire logic [2:0] res = in_img[35:33];
    default clocking dci_cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    // =========================================================
    // device answers
    req_answer_a: assert property ($rose(req) |-> ##[1:6] $onehot(res))
        else $error("request got no single result flag");
    active_len_a: assert property ($rose(in_img[32]) |-> in_img[32] [*4] ##1 (!in_img[32] && $onehot(res)))
        else $error("active flag length or result flag wrong");
    active_excl_a: assert property (in_img[32] |-> res == 3'h0)
        else $error("result flag while still active");
    flag_clear_a: assert property ((res != 3'h0 && !req) |=> in_img[35:32] == 4'h0)
        else $error("flags kept after request drop");
    coerce_ret_a: assert property ($rose(in_img[35]) |-> (in_img[31:0] == dci_pkg::SET_LIMIT && out_img[65]))
        else $error("coerced result without clamped value");
    write_ret_a: assert property (($rose(in_img[33]) && out_img[65]) |-> in_img[31:0] == out_img[63:32])
        else $error("stored value not returned after write");

    // =========================================================
    // controller behaviour
    req_hold_a: assert property ((req && res == 3'h0) |=> $stable(out_img))
        else $error("request fields moved before result");
    rw_excl_a: assert property (!(out_img[64] && out_img[65]))
        else $error("read and write raised together");
    spare_zero_a: assert property (out_img[31:20] == 12'h000 && out_img[71:66] == 6'h00)
        else $error("spare output bits not zero");

    // main scenarios seen at least once
    cover property ($rose(in_img[35]));
    cover property ($rose(in_img[34]));
    cover property ($rose(in_img[33]) && out_img[64]);
    cover property ($changed(ctl2_word) && $changed(style2_word) && $changed(pre1_word));
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench: controller and device joined by the image, plus a bench-driven device
`define DCI_CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic w; logic [11:0] c; logic [7:0] t; logic [31:0] v; logic [2:0] f; logic [31:0] e;} dci_row_type;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic start = 1'h0;
    logic wr = 1'h0;
    logic [11:0] code = 12'h000;
    logic [7:0] tgt = 8'h00;
    logic [31:0] val = 32'h0;
    logic [15:0] ctl2 = 16'h0;
    logic [15:0] style2 = 16'h0;
    logic [15:0] pre1 = 16'h0;
    logic [8:0] styles_b = 9'h010;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    wire logic busy, done, ok, fail, coer, busy_b;
    wire logic [31:0] ret;
    wire logic [7:0] plate;
    wire logic [7:0] style_num;
    wire logic [3:0] pre_on;
    logic [7:0] tgts [8] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hE1, 8'hE2, 8'hE3, 8'hE4};
    // flags column is {coerced, failure, success}; failure keeps the previous returned value
    dci_row_type rows [10] = '{
        '{1'h1, 12'h203, 8'hB0, 32'h4, 3'h1, 32'h4}, '{1'h0, 12'h203, 8'hB0, 32'h0, 3'h1, 32'h4},
        '{1'h1, 12'h20F, 8'hE4, 32'h10000, 3'h4, 32'hFFFF}, '{1'h0, 12'h20F, 8'hE4, 32'h0, 3'h1, 32'hFFFF},
        '{1'h1, 12'h200, 8'hB3, 32'hFFFF, 3'h1, 32'hFFFF}, '{1'h0, 12'h203, 8'hB1, 32'h0, 3'h1, 32'h0},
        '{1'h1, 12'h203, 8'hB4, 32'h9, 3'h2, 32'h0}, '{1'h1, 12'h203, 8'hE0, 32'h9, 3'h2, 32'h0},
        '{1'h0, 12'h210, 8'hB0, 32'h0, 3'h2, 32'h0}, '{1'h0, 12'h1FF, 8'hB0, 32'h0, 3'h2, 32'h0}};

    // =========================================================
    // design under test and checker
    dci_image_if img_a();
    dci_image_if img_b();
    // the bench-faced device sees no plate traffic, so its plate words rest at zero
    assign img_b.ctl2_word = 16'h0000;
    assign img_b.style2_word = 16'h0000;
    assign img_b.pre1_word = 16'h0000;
    dci_host u_dci_host (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .img(img_a.host), .cmd_start_i(start),
        .cmd_write_i(wr), .cmd_code_i(code), .cmd_target_i(tgt), .cmd_value_i(val), .ctl2_word_i(ctl2),
        .style2_word_i(style2), .pre1_word_i(pre1), .cmd_busy_o(busy), .cmd_done_o(done), .cmd_ok_o(ok),
        .cmd_fail_o(fail), .cmd_coerced_o(coer), .cmd_value_o(ret));
    dci_device u_dci_device (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .img(img_a.device), .style_count_i(9'h010),
        .cmd_busy_o(), .style_strobe_o(plate[0]), .dispense_done_o(plate[1]), .valve_on_o(plate[5:2]),
        .error_reset_o(plate[6]), .remote_start_o(plate[7]), .style_num_o(style_num), .precharge_on_o(pre_on));
    // second device faced by the bench so that controller faults can be made on purpose
    dci_device u_dci_device_b (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .img(img_b.device), .style_count_i(styles_b),
        .cmd_busy_o(busy_b), .style_strobe_o(), .dispense_done_o(), .valve_on_o(), .error_reset_o(),
        .remote_start_o(), .style_num_o(), .precharge_on_o());
    dci_checker u_dci_checker (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .out_img(img_a.out_img), .in_img(img_a.in_img),
        .ctl2_word(img_a.ctl2_word), .style2_word(img_a.style2_word), .pre1_word(img_a.pre1_word));

    // =========================================================
    // clock, hang guard and closing report
    always #10 clk_sys = ~clk_sys;
    // a hung handshake would never end the run, so cap it well above the expected ~400 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one command through the controller; field positions checked on the image when the request bit rises
    task automatic run_cmd(input dci_row_type r);
        int n;
        logic seen;
        @(posedge clk_sys);
        start <= 1'h1;
        wr <= r.w;
        code <= r.c;
        tgt <= r.t;
        val <= r.v;
        @(posedge clk_sys);
        start <= 1'h0;
        n = 0;
        seen = 1'h0;
        while (done !== 1'h1 && n < 40) begin
            @(negedge clk_sys);
            n++;
            if (!seen && img_a.out_img[65:64] !== 2'h0) begin
                seen = 1'h1;
                `DCI_CHK(img_a.out_img[65:64], {r.w, ~r.w})
                `DCI_CHK(busy, 1'h1)
                `DCI_CHK(img_a.out_img[19:0], {r.t, r.c})
                if (r.w) `DCI_CHK(img_a.out_img[63:32], r.v)
            end
        end
        `DCI_CHK({done, busy}, 2'h2)
        `DCI_CHK({coer, fail, ok}, r.f)
        `DCI_CHK(ret, r.e)
    endtask
    // bench-driven request on the second image, always plate three, code 0x203
    task automatic set_b(input logic [1:0] rw, input logic [31:0] v);
        @(posedge clk_sys);
        img_b.out_img <= {6'h00, rw, v, 12'h000, 8'hB2, 12'h203};
    endtask
    task automatic see_b(input int n, input logic [3:0] e);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
        `DCI_CHK(img_b.in_img[35:32], e)
    endtask

    // =========================================================
    // main sequence
    initial begin
        img_b.out_img = '0;
        repeat (9) @(posedge clk_sys);
        @(negedge clk_sys);
        `DCI_CHK({img_a.in_img, img_a.out_img, busy, plate}, 117'h0)
        @(posedge clk_sys);
        rst_b <= 1'h1;
        foreach (rows[i]) run_cmd(rows[i]);
        for (int i = 0; i < 16; i++) run_cmd(dci_row_type'{i < 8, 12'h205, tgts[i % 8], 32'h100 + i % 8, 3'h1, 32'h100 + i % 8});
        $display("test command rows done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            ctl2 <= 16'hFF00 | (16'h0001 << i);
            style2 <= {8'hFF, 8'h80 | 8'(i)};
            pre1 <= 16'h00F0 | (16'h0001 << (i % 4));
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            `DCI_CHK(plate, 8'h01 << i)
            `DCI_CHK(style_num, 8'h80 | 8'(i))
            `DCI_CHK(pre_on, 4'h1 << (i % 4))
        end
        $display("test plate words done");
        set_b(2'h3, 32'h5); see_b(8, 4'h4); set_b(2'h0, 32'h0); see_b(2, 4'h0);
        set_b(2'h2, 32'h6); see_b(2, 4'h1); `DCI_CHK(busy_b, 1'h1)
        set_b(2'h3, 32'h6); see_b(6, 4'h4); set_b(2'h0, 32'h0); see_b(2, 4'h0);
        @(posedge clk_sys) styles_b <= 9'h020;
        set_b(2'h2, 32'h7); see_b(8, 4'h0); set_b(2'h0, 32'h0);
        @(posedge clk_sys) styles_b <= 9'h100;
        set_b(2'h2, 32'h55); see_b(6, 4'h2); `DCI_CHK(img_b.in_img[31:0], 32'h55)
        set_b(2'h0, 32'h0); see_b(2, 4'h0);
        set_b(2'h2, 32'h77); see_b(2, 4'h1); set_b(2'h0, 32'h0); see_b(2, 4'h0);
        set_b(2'h1, 32'h0); see_b(6, 4'h2); `DCI_CHK(img_b.in_img[31:0], 32'h55)
        set_b(2'h0, 32'h0); see_b(2, 4'h0);
        $display("test bench-driven device done");
        // a request held through reset must be ignored until it has been seen low
        set_b(2'h1, 32'h0);
        @(posedge clk_sys) rst_b <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'h1;
        see_b(8, 4'h0); set_b(2'h0, 32'h0); see_b(2, 4'h0);
        set_b(2'h1, 32'h0); see_b(6, 4'h2); `DCI_CHK(img_b.in_img[31:0], 32'h0)
        $display("test mid-run reset done");
        results();
    end
endmodule
